// ==== design/wsg_pkg.sv ====
// Package with register map, field layout and constants of the wait-state generator.
package wsg_pkg;
  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PADDR_W = 23;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned COUNT_W = 4;
  localparam logic [ADDR_W-1:0] RANGES_ADDR = 16'h0028;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 16'h002b;
  localparam int unsigned IO_LSB = 12;
  localparam int unsigned DHI_LSB = 9;
  localparam int unsigned DLO_LSB = 6;
  localparam int unsigned PHI_LSB = 3;
  localparam int unsigned PLO_LSB = 0;
  localparam int unsigned EXT_SELECT_BIT = 15;
  localparam int unsigned DOUBLER_BIT = 0;
  localparam logic [REG_W-1:0] RANGES_RESET = 16'h7fff;
  localparam logic [REG_W-1:0] RANGES_ZERO_MASK = 16'h7fff;
  localparam logic [REG_W-1:0] CONTROL_MASK = 16'h0001;
  localparam int unsigned LOW_SPLIT_BIT = 15;
  localparam int unsigned EXT_SPLIT_BIT = 22;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 4'h1;
  localparam logic [FIELD_W-1:0] FIELD_ZERO = 3'h0;
  typedef enum logic [1:0] {
    WSG_SPACE_PROG,
    WSG_SPACE_DATA,
    WSG_SPACE_IO
  } wsg_space_type;
endpackage

// ==== design/wsg_regs.sv ====
// Memory-mapped wait-state range and control registers.
`timescale 1ns/1ps
module wsg_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [wsg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wsg_pkg::REG_W-1:0] reg_wdata,
  output logic [wsg_pkg::REG_W-1:0] reg_rdata,
  output logic [wsg_pkg::REG_W-1:0] wait_state_ranges,
  output logic [wsg_pkg::REG_W-1:0] wait_state_control
);
  logic hit_ranges;
  logic hit_control;
  logic [wsg_pkg::REG_W-1:0] next_rdata;

  // Address decode; unmapped reads return zero.
  assign hit_ranges = reg_addr == wsg_pkg::RANGES_ADDR;
  assign hit_control = reg_addr == wsg_pkg::CONTROL_ADDR;
  assign next_rdata = hit_ranges ? wait_state_ranges :
                      hit_control ? wait_state_control : '0;

  // Both registers reset so that every range gets seven waits and doubling is off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_state_ranges <= wsg_pkg::RANGES_RESET;
      wait_state_control <= '0;
    end else if (reg_wr && hit_ranges) begin
      wait_state_ranges <= reg_wdata;
    end else if (reg_wr && hit_control) begin
      wait_state_control <= reg_wdata & wsg_pkg::CONTROL_MASK;
    end
  end

  // Read data is registered, so it appears one cycle after the read strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  upper_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    wait_state_control[wsg_pkg::REG_W-1:1] == '0)
    else $error("reserved control bits not zero");
endmodule // wsg_regs

// ==== design/wsg_counter.sv ====
// Down counter that holds an access for its wait states and the ready input.
`timescale 1ns/1ps
module wsg_counter #(
  parameter int unsigned COUNT_W = wsg_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_gate_en,
  input wire logic start,
  input wire logic [COUNT_W-1:0] load,
  input wire logic ready_sync,
  output logic busy,
  output logic done
);
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic expired;

  assign expired = count == '0;
  // The access ends only once the count is spent and ready is seen.
  assign done = busy && expired && ready_sync;
  assign next_count = (!expired && clk_gate_en) ? count - COUNT_W'(1) : count;

  // The counter only advances while its gated clock is enabled; with zero waits
  // everywhere it stays at zero and costs no toggling.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      busy <= 1'b0;
    end else if (start) begin
      count <= load;
      busy <= 1'b1;
    end else begin
      count <= next_count;
      busy <= busy && !done;
    end
  end

  no_early_end_a: assert property (@(posedge clk) disable iff (!rstn)
    done |-> count == '0)
    else $error("access ended with waits pending");
endmodule // wsg_counter

// ==== design/wsg_top.sv ====
// Wait-state generator: range decode, multiplier and access sequencing.
`timescale 1ns/1ps
module wsg_top #(
  parameter int unsigned PADDR_W = wsg_pkg::PADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [wsg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [wsg_pkg::REG_W-1:0] reg_wdata,
  output logic [wsg_pkg::REG_W-1:0] reg_rdata,
  input wire logic acc_start,
  input wire logic [1:0] acc_space,
  input wire logic [PADDR_W-1:0] acc_addr,
  input wire logic ready,
  output logic acc_busy,
  output logic acc_done,
  output logic wait_clk_en,
  output logic [wsg_pkg::COUNT_W-1:0] acc_waits
);
  logic [wsg_pkg::REG_W-1:0] wait_state_ranges;
  logic [wsg_pkg::REG_W-1:0] wait_state_control;
  logic ready_meta;
  logic ready_sync;
  logic extended_program_range_select;
  logic wait_count_doubler;
  logic prog_upper;
  logic data_upper;
  logic [wsg_pkg::FIELD_W-1:0] base_count;
  logic [wsg_pkg::FIELD_W-1:0] io_field;
  logic [wsg_pkg::FIELD_W-1:0] dhi_field;
  logic [wsg_pkg::FIELD_W-1:0] dlo_field;
  logic [wsg_pkg::FIELD_W-1:0] phi_field;
  logic [wsg_pkg::FIELD_W-1:0] plo_field;
  logic [wsg_pkg::FIELD_W-1:0] prog_field;
  logic [wsg_pkg::FIELD_W-1:0] data_field;
  logic is_prog;
  logic is_data;
  logic [wsg_pkg::COUNT_W-1:0] total_count;
  wsg_pkg::wsg_space_type space;

  // Slice a 3-bit field out of the range register.
  function automatic logic [wsg_pkg::FIELD_W-1:0] field_at(
    input logic [wsg_pkg::REG_W-1:0] r, input int unsigned lsb);
    field_at = r[lsb +: wsg_pkg::FIELD_W];
  endfunction

  wsg_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .wait_state_ranges(wait_state_ranges),
    .wait_state_control(wait_state_control)
  );

  // Ready comes from an external pin, so it is synchronised before use.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
    end else begin
      ready_meta <= ready;
      ready_sync <= ready_meta;
    end
  end

  assign extended_program_range_select = wait_state_ranges[wsg_pkg::EXT_SELECT_BIT];
  assign wait_count_doubler = wait_state_control[wsg_pkg::DOUBLER_BIT];
  assign space = wsg_pkg::wsg_space_type'(acc_space);

  // Range decode; the extended split looks at the top of the 23-bit program address.
  assign prog_upper = extended_program_range_select ?
                      acc_addr[wsg_pkg::EXT_SPLIT_BIT] :
                      acc_addr[wsg_pkg::LOW_SPLIT_BIT];
  assign data_upper = acc_addr[wsg_pkg::LOW_SPLIT_BIT];

  // Every field is cut out once, so the selection below is a plain mux tree.
  assign io_field = field_at(wait_state_ranges, wsg_pkg::IO_LSB);
  assign dhi_field = field_at(wait_state_ranges, wsg_pkg::DHI_LSB);
  assign dlo_field = field_at(wait_state_ranges, wsg_pkg::DLO_LSB);
  assign phi_field = field_at(wait_state_ranges, wsg_pkg::PHI_LSB);
  assign plo_field = field_at(wait_state_ranges, wsg_pkg::PLO_LSB);
  assign prog_field = prog_upper ? phi_field : plo_field;
  assign data_field = data_upper ? dhi_field : dlo_field;
  assign is_prog = space == wsg_pkg::WSG_SPACE_PROG;
  assign is_data = space == wsg_pkg::WSG_SPACE_DATA;

  // Space select; the spare space code falls back to the I/O field, which is the
  // safe choice because I/O devices are usually the slowest on the bus.
  assign base_count = is_prog ? prog_field :
                      is_data ? data_field : io_field;

  // Doubling is a left shift, which keeps the multiplier out of the path.
  assign total_count = wait_count_doubler ? {base_count, 1'b0} :
                       {1'b0, base_count};

  // Clock gate: any non-zero field, or doubling of one, needs the counter.
  assign wait_clk_en = (wait_state_ranges & wsg_pkg::RANGES_ZERO_MASK) != '0;

  wsg_counter #(
    .COUNT_W(wsg_pkg::COUNT_W)
  ) u_counter (
    .clk(clk),
    .rstn(rstn),
    .clk_gate_en(wait_clk_en),
    .start(acc_start),
    .load(total_count),
    .ready_sync(ready_sync),
    .busy(acc_busy),
    .done(acc_done)
  );

  // Waits granted to the access in progress, visible for debug.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_waits <= '0;
    end else if (acc_start) begin
      acc_waits <= total_count;
    end
  end

  // Access timing: the start edge loads the count and raises busy, and each later edge
  // takes one wait off the count while the gate is open. Once the count is spent, done
  // rises in a cycle in which synchronised ready is high, so N waits give N plus one busy
  // cycles at best. Ready passes two flip-flops, so a device must drop it at once after
  // the start edge to stretch a short access; a longer programmed count hides this lag.
  // Counts cycles of the current access for the assertions.
  logic [4:0] acc_cycles;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_cycles <= '0;
    end else if (acc_start) begin
      acc_cycles <= '0;
    end else if (acc_busy && acc_cycles != 5'h1f) begin
      acc_cycles <= acc_cycles + 5'h01;
    end
  end

  max_waits_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_waits <= 4'd14)
    else $error("wait count above fourteen");

  double_count_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_start && wait_count_doubler |=> acc_waits == {$past(base_count), 1'b0})
    else $error("doubler not applied");

  doubled_value_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_start |=> acc_waits == $past(wait_count_doubler ? {base_count, 1'b0}
                                     : {1'b0, base_count}))
    else $error("granted waits differ from selected field");

  plain_value_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_start && !wait_count_doubler |=> acc_waits == {1'b0, $past(base_count)})
    else $error("undoubled count wrong");

  io_field_a: assert property (@(posedge clk) disable iff (!rstn)
    space == wsg_pkg::WSG_SPACE_IO |-> base_count == wait_state_ranges[14:12])
    else $error("io field not selected");

  data_field_a: assert property (@(posedge clk) disable iff (!rstn)
    space == wsg_pkg::WSG_SPACE_DATA |->
      base_count == (acc_addr[15] ? wait_state_ranges[11:9] : wait_state_ranges[8:6]))
    else $error("data field not selected");

  prog_field_a: assert property (@(posedge clk) disable iff (!rstn)
    space == wsg_pkg::WSG_SPACE_PROG |->
      base_count == ((wait_state_ranges[15] ? acc_addr[22] : acc_addr[15]) ?
                     wait_state_ranges[5:3] : wait_state_ranges[2:0]))
    else $error("program field not selected");

  gate_off_a: assert property (@(posedge clk) disable iff (!rstn)
    wait_state_ranges[14:0] == '0 |-> !wait_clk_en)
    else $error("gate open with all zero waits");

  wait_ready_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_done |-> ready_sync && acc_cycles >= 5'(acc_waits))
    else $error("access ended before waits and ready");

  reset_seven_a: assert property (@(posedge clk)
    $rose(rstn) |-> wait_state_ranges == wsg_pkg::RANGES_RESET)
    else $error("range reset value wrong");

  ext_reset_a: assert property (@(posedge clk)
    $rose(rstn) |-> !extended_program_range_select)
    else $error("extended split not clear after reset");

  doubler_reset_a: assert property (@(posedge clk)
    $rose(rstn) |-> !wait_count_doubler)
    else $error("doubler not clear after reset");

  // Gating: a closed gate must never meet a non-zero count, or an access would hang.
  gate_counts_a: assert property (@(posedge clk) disable iff (!rstn)
    !wait_clk_en |-> total_count == '0)
    else $error("gate closed with waits to insert");

  // Access sequencing guards.
  busy_start_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_start |=> acc_busy)
    else $error("busy not raised by start");

  busy_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_busy && !acc_done && !acc_start |=> acc_busy)
    else $error("access dropped before done");

  busy_end_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_done && !acc_start |=> !acc_busy)
    else $error("busy held after done");

  ready_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_busy && !ready_sync |-> !acc_done)
    else $error("access ended while ready inactive");

  waits_held_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_busy && !acc_start |=> $stable(acc_waits))
    else $error("granted waits changed mid access");

  doubled_even_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_start && wait_count_doubler |=> !acc_waits[0])
    else $error("doubled count is odd");

  plain_small_a: assert property (@(posedge clk) disable iff (!rstn)
    acc_start && !wait_count_doubler |=> !acc_waits[wsg_pkg::COUNT_W-1])
    else $error("undoubled count above seven");

  // Program split guards, one per split and half.
  ext_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    is_prog && extended_program_range_select && acc_addr[wsg_pkg::EXT_SPLIT_BIT] |->
      base_count == wait_state_ranges[wsg_pkg::PHI_LSB +: wsg_pkg::FIELD_W])
    else $error("extended upper program field not selected");

  ext_lower_a: assert property (@(posedge clk) disable iff (!rstn)
    is_prog && extended_program_range_select && !acc_addr[wsg_pkg::EXT_SPLIT_BIT] |->
      base_count == wait_state_ranges[wsg_pkg::PLO_LSB +: wsg_pkg::FIELD_W])
    else $error("extended lower program field not selected");

  low_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    is_prog && !extended_program_range_select && acc_addr[wsg_pkg::LOW_SPLIT_BIT] |->
      base_count == wait_state_ranges[wsg_pkg::PHI_LSB +: wsg_pkg::FIELD_W])
    else $error("upper program field not selected");

  low_lower_a: assert property (@(posedge clk) disable iff (!rstn)
    is_prog && !extended_program_range_select && !acc_addr[wsg_pkg::LOW_SPLIT_BIT] |->
      base_count == wait_state_ranges[wsg_pkg::PLO_LSB +: wsg_pkg::FIELD_W])
    else $error("lower program field not selected");

  // Register bus guards.
  ranges_write_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == wsg_pkg::RANGES_ADDR |=> wait_state_ranges == $past(reg_wdata))
    else $error("range write lost");

  control_write_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == wsg_pkg::CONTROL_ADDR |=>
      wait_state_control[wsg_pkg::DOUBLER_BIT] == $past(reg_wdata[wsg_pkg::DOUBLER_BIT]) &&
      wait_state_control[wsg_pkg::REG_W-1:1] == '0)
    else $error("control write wrong");

  ranges_read_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == wsg_pkg::RANGES_ADDR |=> reg_rdata == $past(wait_state_ranges))
    else $error("range read data wrong");

  control_read_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == wsg_pkg::CONTROL_ADDR |=> reg_rdata[wsg_pkg::REG_W-1:1] == '0)
    else $error("reserved control bits read non-zero");

  zero_wait_c: cover property (@(posedge clk) disable iff (!rstn)
    acc_start && total_count == '0 ##1 acc_done);
  max_wait_c: cover property (@(posedge clk) disable iff (!rstn)
    acc_start && total_count == 4'd14);
  ready_hold_c: cover property (@(posedge clk) disable iff (!rstn)
    acc_busy && !ready_sync ##1 acc_busy && !ready_sync ##1 acc_done);
  ext_prog_c: cover property (@(posedge clk) disable iff (!rstn)
    acc_start && extended_program_range_select && space == wsg_pkg::WSG_SPACE_PROG);
  doubled_c: cover property (@(posedge clk) disable iff (!rstn)
    acc_start && wait_count_doubler && base_count != '0);
endmodule // wsg_top

// ==== bench/wsg_ext_dev.sv ====
// Behavioural model of a slow external device that holds ready low for a set count.
`timescale 1ns/1ps
module wsg_ext_dev (
  input wire logic clk,
  input wire logic rstn,
  input wire logic acc_start,
  input wire logic [7:0] hold,
  output logic ready
);
  logic [7:0] left;
  // A nonzero hold drops ready from the start edge, so a hold of at least the waits stretches an access of two or more waits.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left <= 8'h00;
    end else if (acc_start) begin
      left <= hold;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Ready is active high and idles high, so fast devices never stretch an access.
  assign ready = (left == 8'h00);
endmodule // wsg_ext_dev

// ==== bench/wsg_top_test.sv ====
// Self-checking testbench of the wait-state generator with a slow-device partner.
`timescale 1ns/1ps
module wsg_top_test;
  typedef struct {logic [3:0] waits; int lo; int hi;} wsg_note_type;
  logic clk, rstn, reg_wr, reg_rd, acc_start, ready, acc_busy, acc_done, wait_clk_en;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, r;
  logic [1:0] acc_space;
  logic [22:0] acc_addr, ra;
  logic [7:0] dev_hold;
  logic [3:0] acc_waits, ew;
  logic dbl, done_seen;
  wsg_note_type notes[$];
  wsg_note_type nt;
  int fail_count, n_tests, lat, cycles;
  wsg_top wsg_top_inst (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .acc_start(acc_start), .acc_space(acc_space), .acc_addr(acc_addr), .ready(ready),
    .acc_busy(acc_busy), .acc_done(acc_done), .wait_clk_en(wait_clk_en),
    .acc_waits(acc_waits));
  wsg_ext_dev wsg_ext_dev_inst (.clk(clk), .rstn(rstn), .acc_start(acc_start),
    .hold(dev_hold), .ready(ready));
  always #2.5 clk = ~clk;
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, e);
  endtask
  // Expected count: field picked by space and address, then doubled on request.
  function automatic logic [3:0] waits_of(logic [1:0] s, logic [22:0] a);
    logic [2:0] f;
    if (s >= 2'd2) f = r[14:12];
    else if (s == 2'd1) f = a[15] ? r[11:9] : r[8:6];
    else f = (r[15] ? a[22] : a[15]) ? r[5:3] : r[2:0];
    return dbl ? {f, 1'b0} : {1'b0, f};
  endfunction
  // The driver notes what it expects, then waits a bounded time for the monitor.
  task automatic acc(logic [1:0] s, logic [22:0] a, logic [7:0] h, int lo, int hi);
    int n;
    done_seen = 1'b0;
    @(posedge clk);
    acc_start <= 1'b1;
    acc_space <= s;
    acc_addr <= a;
    dev_hold <= h;
    notes.push_back('{waits_of(s, a), lo, hi});
    @(posedge clk);
    acc_start <= 1'b0;
    n = 0;
    while (!done_seen && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (!done_seen) check("acc_done", 16'h0000, 16'h0001);
  endtask
  // Monitor counts busy cycles at the falling edge, where outputs are settled.
  always @(negedge clk) begin
    if (acc_busy === 1'b1) lat++;
    if (acc_done === 1'b1) begin
      if (notes.size() == 0) check("acc_unexpected", 16'h0001, 16'h0000);
      else begin
        nt = notes.pop_front();
        check("acc_waits", {12'h000, acc_waits}, {12'h000, nt.waits});
        check("acc_latency", 16'(lat >= nt.lo && lat <= nt.hi), 16'h0001);
      end
      lat = 0;
      done_seen = 1'b1;
    end
  end
  // Hang guard: the whole run needs far fewer cycles than this.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    {clk, reg_wr, reg_rd, acc_start, dbl} = 5'b00000;
    {reg_addr, reg_wdata, r} = 48'h0;
    {acc_space, acc_addr, dev_hold} = 33'h0;
    fail_count = 0;
    n_tests = 0;
    lat = 0;
    cycles = 0;
    rstn = 1'b0;
    void'($urandom(32'h8cabcec8));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(wsg_pkg::RANGES_ADDR, 16'h7fff);
    rd(wsg_pkg::CONTROL_ADDR, 16'h0000);
    r = 16'h7fff;
    acc(2'd0, 23'h00_0000, 8'h00, 8, 8);
    rd(16'h0030, 16'h0000);
    wr(wsg_pkg::CONTROL_ADDR, 16'hfffe);
    rd(wsg_pkg::CONTROL_ADDR, 16'h0000);
    // Random fields, split bit and doubler, with each of the three spaces in turn at random addresses.
    for (int i = 0; i < 40; i++) begin
      r = 16'($urandom());
      dbl = 1'($urandom());
      wr(wsg_pkg::RANGES_ADDR, r);
      wr(wsg_pkg::CONTROL_ADDR, {15'($urandom()), dbl});
      rd(wsg_pkg::RANGES_ADDR, r);
      rd(wsg_pkg::CONTROL_ADDR, {15'h0000, dbl});
      #1 check("wait_clk_en", {15'h0000, wait_clk_en}, {15'h0000, r[14:0] != 15'h0});
      for (int j = 0; j < 3; j++) begin
        ra = 23'($urandom());
        ew = waits_of(2'(j), ra);
        acc(2'(j), ra, 8'h00, ew + 1, ew + 1);
      end
    end
    // Fourteen waits at the top of the range, then all ranges at zero.
    r = 16'h7000;
    dbl = 1'b1;
    wr(wsg_pkg::RANGES_ADDR, r);
    wr(wsg_pkg::CONTROL_ADDR, 16'h0001);
    acc(2'd3, 23'h00_ffff, 8'h00, 15, 15);
    r = 16'h8000;
    wr(wsg_pkg::RANGES_ADDR, r);
    #1 check("wait_clk_en", {15'h0000, wait_clk_en}, 16'h0000);
    acc(2'd0, 23'h40_0000, 8'h00, 1, 1);
    // A slow device outlasts two programmed waits through the ready input.
    r = 16'h2000;
    dbl = 1'b0;
    wr(wsg_pkg::RANGES_ADDR, r);
    wr(wsg_pkg::CONTROL_ADDR, 16'h0000);
    acc(2'd2, 23'h00_1234, 8'h0c, 13, 17);
    summarize();
  end
endmodule // wsg_top_test
